// ===== verilog/swu_pkg.sv
// Constants for the chip watchdog unit: register offsets, fields, codes, timing.
// Assumes a 200 MHz clock and one register access port from the SPI decoder.
`default_nettype none
package swu_pkg;
    localparam logic [6:0] ADDR_WD_CTRL   = 7'h00;
    localparam logic [6:0] ADDR_WD_STATE  = 7'h05;
    localparam logic [6:0] ADDR_NV_CONFIG = 7'h74;
    // Control register fields
    localparam int MODE_LSB   = 5;
    localparam int PERIOD_LSB = 0;
    localparam logic [2:0] MODE_AUTO    = 3'h1;
    localparam logic [2:0] MODE_TIMEOUT = 3'h2;
    localparam logic [2:0] MODE_WINDOW  = 3'h4;
    localparam logic [3:0] PER_8    = 4'h8;
    localparam logic [3:0] PER_16   = 4'h1;
    localparam logic [3:0] PER_32   = 4'h2;
    localparam logic [3:0] PER_64   = 4'hb;
    localparam logic [3:0] PER_128  = 4'h4;
    localparam logic [3:0] PER_256  = 4'hd;
    localparam logic [3:0] PER_1024 = 4'he;
    localparam logic [3:0] PER_4096 = 4'h7;
    // Config register fields and factory presets
    localparam int CFG_UV_LSB  = 4;
    localparam int CFG_FN_BIT  = 3;
    localparam int CFG_SD_BIT  = 2;
    localparam int CFG_SLP_BIT = 0;
    localparam logic [7:0] CFG_PRESET = 8'h08;
    localparam logic [7:0] CFG_WMASK  = 8'h3d;
    // Status register fields
    localparam int ST_FN_BIT = 3;
    localparam int ST_SD_BIT = 2;
    localparam logic [1:0] PH_OFF    = 2'h0;
    localparam logic [1:0] PH_FIRST  = 2'h1;
    localparam logic [1:0] PH_SECOND = 2'h2;
    // Reset source codes
    localparam logic [4:0] RSC_EARLY    = 5'h0e;
    localparam logic [4:0] RSC_OVERFLOW = 5'h0f;
    localparam logic [4:0] RSC_ILLEGAL  = 5'h10;
    // Timing: one millisecond tick
    localparam int CLK_HZ        = 200_000_000;
    localparam int TICK_NS       = 1_000_000;
    localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_NS / 1_000;
    typedef enum logic [2:0]
    {
        CHIP_OFF     = 3'h0,
        CHIP_RESET   = 3'h1,
        CHIP_STANDBY = 3'h2,
        CHIP_NORMAL  = 3'h3,
        CHIP_SLEEP   = 3'h4,
        CHIP_OTEMP   = 3'h5
    } swu_chip_mode_t;
endpackage
`default_nettype wire

// ===== verilog/swu_tick_div.sv
// Divider making a one-cycle enable every millisecond.
// Assumes the single system clock.
`default_nettype none
module swu_tick_div #(
    parameter int DIV = swu_pkg::TICK_CYCLES
)(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    output logic      o_tick
);
    logic [31:0] cnt_reg;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg <= 32'h0000_0000;
            o_tick  <= 1'b0;
        end
        else if (cnt_reg == 32'(DIV - 1))
        begin
            cnt_reg <= 32'h0000_0000;
            o_tick  <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            o_tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/swu_watchdog.sv
// Watchdog unit of the chip: control, state and non-volatile config registers.
// Assumes the SPI decoder presents one-cycle write/read strobes synchronous to i_clk.
`default_nettype none
// How it works
// - Each valid control register write, except a change in Normal, is a trigger and restarts the timer.
// - Changed mode or period takes effect immediately on the trigger.
// - Period codes are redundant; valid codes differ in two bits or more.
// - Invalid mode or period code abandons the write and flags SPI failure.
// - Window code runs Window only in Normal; written in Standby, waits for Normal.
// - Timeout code runs Timeout in Normal, Standby, Sleep; Window code too in Standby and Sleep.
// - Autonomous without sw-dev: Timeout in Normal or Standby with wake pending.
// - Autonomous with sw-dev: watchdog off in every mode.
// - Sw-dev makes mode field reset to Autonomous code.
// - Forced normal disables the watchdog timer; a mode or period change in Normal still forces reset.
// - Window trigger is accepted only in the second half, restarting the timer.
// - Window overflow or early trigger resets the chip with identifying source.
// - Timeout trigger restarts anytime; first overflow sets pending failure event.
// - Timeout overflow with failure pending resets the chip.
// - Phase field: 00 off, 01 first half, 10 second half.
// - Status bit 3 forced normal, bit 2 software development.
// - Config bit 3 forced normal preset 1, bit 2 sw-dev preset 0.
// - Config bits 5:4 give start-up undervoltage threshold, preset 00.
// - Config bit 0 set ignores Sleep commands, preset 0.
// - Mode or period change in Normal forces reset, source 10000, SPI failure.
// - Period defaults to 128 ms, used for both Window and Timeout.
// - Source 01110 early trigger, 01111 overflow.
module swu_watchdog #(
    parameter int TICK_DIV = swu_pkg::TICK_CYCLES
)(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_chip_mode,
    input  wire logic       i_rx_wake_n,
    input  wire logic       i_spi_fail_event_en,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [6:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wd_fail_clr,
    output logic [7:0]      o_rdata,
    output logic            o_reset_req,
    output logic [4:0]      o_reset_source_code,
    output logic            o_spi_fail_event,
    output logic            o_wd_fail_event,
    output logic [1:0]      o_uv_threshold_sel,
    output logic            o_sleep_lock_ctrl,
    output logic            o_forced_normal_state
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] period_ms(input logic [3:0] code);
        unique case (code)
            swu_pkg::PER_8:    period_ms = 12'd8;
            swu_pkg::PER_16:   period_ms = 12'd16;
            swu_pkg::PER_32:   period_ms = 12'd32;
            swu_pkg::PER_64:   period_ms = 12'd64;
            swu_pkg::PER_128:  period_ms = 12'd128;
            swu_pkg::PER_256:  period_ms = 12'd256;
            swu_pkg::PER_1024: period_ms = 12'd1024;
            swu_pkg::PER_4096: period_ms = 12'd4095;
            default:           period_ms = 12'd0;
        endcase
    endfunction

    logic [2:0]  wd_mode_sel_reg;
    logic [3:0]  wd_period_sel_reg;
    logic [7:0]  cfg_reg;
    logic [12:0] timer_reg;
    logic        wd_fail_event_reg;
    logic        tick;
    logic        forced_normal_ctrl;
    logic        sw_dev_ctrl;
    logic        in_normal;
    logic        in_stby_sleep;
    logic        wr_ctrl;
    logic        code_ok;
    logic        changed;
    logic        trig;
    logic        run_window;
    logic        run_timeout;
    logic        running;
    logic [12:0] period_ticks;
    logic        second_half;
    logic        overflow;
    logic [1:0]  wd_phase_state;

    swu_tick_div #(.DIV(TICK_DIV)) u_div
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write decode and code check
    assign forced_normal_ctrl = cfg_reg[swu_pkg::CFG_FN_BIT];
    assign sw_dev_ctrl        = cfg_reg[swu_pkg::CFG_SD_BIT];
    assign in_normal     = (i_chip_mode == swu_pkg::CHIP_NORMAL);
    assign in_stby_sleep = (i_chip_mode == swu_pkg::CHIP_STANDBY) || (i_chip_mode == swu_pkg::CHIP_SLEEP);
    assign wr_ctrl = i_wr && (i_addr == swu_pkg::ADDR_WD_CTRL);
    assign code_ok = (i_wdata[7:5] == swu_pkg::MODE_AUTO || i_wdata[7:5] == swu_pkg::MODE_TIMEOUT
                      || i_wdata[7:5] == swu_pkg::MODE_WINDOW)
                     && (period_ms(i_wdata[3:0]) != 12'd0);
    assign changed = (i_wdata[7:5] != wd_mode_sel_reg) || (i_wdata[3:0] != wd_period_sel_reg);
    assign trig    = wr_ctrl && code_ok && !(in_normal && changed);

    ////////////////////////////////////////////////////////////////////////////
    // Effective watchdog operation
    always_comb
    begin
        run_window  = 1'b0;
        run_timeout = 1'b0;
        if (!forced_normal_ctrl)
        begin
            unique case (wd_mode_sel_reg)
                swu_pkg::MODE_WINDOW:
                begin
                    run_window  = in_normal;
                    run_timeout = in_stby_sleep;
                end
                swu_pkg::MODE_TIMEOUT: run_timeout = in_normal || in_stby_sleep;
                swu_pkg::MODE_AUTO:
                    run_timeout = !sw_dev_ctrl && (in_normal
                                  || (i_chip_mode == swu_pkg::CHIP_STANDBY && !i_rx_wake_n));
                default: run_timeout = 1'b0;
            endcase
        end
    end
    assign running      = run_window || run_timeout;
    assign period_ticks = {1'b0, period_ms(wd_period_sel_reg)} + ((wd_period_sel_reg == swu_pkg::PER_4096)
                          ? 13'd1 : 13'd0);
    assign second_half  = (timer_reg >= {1'b0, period_ticks[12:1]});
    assign overflow     = running && tick && !trig && (timer_reg + 13'd1 >= period_ticks);
    assign wd_phase_state = !running ? swu_pkg::PH_OFF
                          : (second_half ? swu_pkg::PH_SECOND : swu_pkg::PH_FIRST);

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wd_mode_sel_reg   <= swu_pkg::MODE_TIMEOUT;
            wd_period_sel_reg <= swu_pkg::PER_128;
        end
        else if (o_reset_req && sw_dev_ctrl)
            wd_mode_sel_reg <= swu_pkg::MODE_AUTO;
        else if (trig)
        begin
            wd_mode_sel_reg   <= i_wdata[7:5];
            wd_period_sel_reg <= i_wdata[3:0];
        end
    end

    // Non-volatile configuration; forced normal output follows after first clock
    logic cfg_init_reg;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cfg_reg <= swu_pkg::CFG_PRESET;
        else if (i_wr && i_addr == swu_pkg::ADDR_NV_CONFIG)
            cfg_reg <= i_wdata & swu_pkg::CFG_WMASK;
    end
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cfg_init_reg <= 1'b0;
        else
            cfg_init_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            timer_reg <= 13'h0000;
        else if (!running || trig || overflow)
            timer_reg <= 13'h0000;
        else if (tick)
            timer_reg <= timer_reg + 13'd1;
    end

    // Pending failure event; set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wd_fail_event_reg <= 1'b0;
        else if (overflow && run_timeout && !wd_fail_event_reg)
            wd_fail_event_reg <= 1'b1;
        else if (i_wd_fail_clr)
            wd_fail_event_reg <= 1'b0;
    end

    // Reset request and source
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_reset_req         <= 1'b0;
            o_reset_source_code <= 5'h00;
        end
        else
        begin
            o_reset_req <= 1'b0;
            if (wr_ctrl && code_ok && in_normal && changed)
            begin
                o_reset_req         <= 1'b1;
                o_reset_source_code <= swu_pkg::RSC_ILLEGAL;
            end
            else if (trig && run_window && !second_half)
            begin
                o_reset_req         <= 1'b1;
                o_reset_source_code <= swu_pkg::RSC_EARLY;
            end
            else if (overflow && (run_window || wd_fail_event_reg))
            begin
                o_reset_req         <= 1'b1;
                o_reset_source_code <= swu_pkg::RSC_OVERFLOW;
            end
        end
    end

    // SPI failure pulse
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_spi_fail_event <= 1'b0;
        else
            o_spi_fail_event <= i_spi_fail_event_en && wr_ctrl && (!code_ok || (in_normal && changed));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            unique case (i_addr)
                swu_pkg::ADDR_WD_CTRL:   o_rdata <= {wd_mode_sel_reg, 1'b0, wd_period_sel_reg};
                swu_pkg::ADDR_WD_STATE:  o_rdata <= {4'h0, forced_normal_ctrl, sw_dev_ctrl, wd_phase_state};
                swu_pkg::ADDR_NV_CONFIG: o_rdata <= cfg_reg;
                default:                 o_rdata <= 8'h00;
            endcase
        end
    end

    assign o_wd_fail_event       = wd_fail_event_reg;
    assign o_uv_threshold_sel    = cfg_reg[swu_pkg::CFG_UV_LSB +: 2];
    assign o_sleep_lock_ctrl     = cfg_reg[swu_pkg::CFG_SLP_BIT];
    assign o_forced_normal_state = forced_normal_ctrl & cfg_init_reg;

    ////////////////////////////////////////////////////////////////////////////
    a_bad_code_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_ctrl && !code_ok |=> $stable(wd_mode_sel_reg) && $stable(wd_period_sel_reg))
        else $error("invalid code updated control");
    a_fn_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        forced_normal_ctrl |-> wd_phase_state == swu_pkg::PH_OFF)
        else $error("watchdog runs in forced normal");
    a_illegal_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_ctrl && code_ok && in_normal && changed |=> o_reset_req && o_reset_source_code == swu_pkg::RSC_ILLEGAL)
        else $error("normal mode change no reset");
    a_early_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        trig && run_window && !second_half |=> o_reset_req && o_reset_source_code == swu_pkg::RSC_EARLY)
        else $error("early trigger no reset");
    a_fail_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        overflow && run_timeout && !wd_fail_event_reg |=> wd_fail_event_reg && !o_reset_req)
        else $error("first overflow wrong");
    a_fail_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        overflow && run_timeout && wd_fail_event_reg |=> o_reset_req)
        else $error("second overflow no reset");
    a_trig_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        trig |=> timer_reg == 13'h0000)
        else $error("trigger no restart");
    a_other_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !in_normal && !in_stby_sleep |-> !running)
        else $error("running in other mode");
    a_auto_sd_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wd_mode_sel_reg == swu_pkg::MODE_AUTO && sw_dev_ctrl |-> !running)
        else $error("autonomous sw-dev running");
    a_late_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        trig && run_window && second_half |=> !o_reset_req && timer_reg == 13'h0000)
        else $error("late window trigger not accepted");
    a_win_overflow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        overflow && run_window && !wr_ctrl |=> o_reset_req && o_reset_source_code == swu_pkg::RSC_OVERFLOW)
        else $error("window overflow no reset");
    a_spi_fail_event_bad: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_spi_fail_event_en && wr_ctrl && !code_ok |=> o_spi_fail_event)
        else $error("invalid code no spi failure");
    a_spi_fail_event_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_spi_fail_event_en |=> !o_spi_fail_event)
        else $error("spi failure while disabled");
    a_auto_stby_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wd_mode_sel_reg == swu_pkg::MODE_AUTO && i_chip_mode == swu_pkg::CHIP_STANDBY && i_rx_wake_n |-> !running)
        else $error("autonomous runs without wake");
    a_sd_auto_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_reset_req && sw_dev_ctrl |=> wd_mode_sel_reg == swu_pkg::MODE_AUTO)
        else $error("sw-dev mode not autonomous after reset");
endmodule
`default_nettype wire

// ===== sim/swu_host_model.sv
// Host microcontroller model: register writes and reads on the one-cycle strobe port.
// Assumes the watchdog samples its strobes on the rising edge of i_clk.
`default_nettype none
module swu_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic [6:0]      o_addr,
    output logic [7:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 7'h7f;
        o_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Each write is a one-cycle strobe; released lines show inverted values
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge i_clk);
        #1;
        o_wr    = 1'b1;
        o_addr  = a;
        o_wdata = v;
        @(posedge i_clk);
        #1;
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~v;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge i_clk);
        #1;
        o_rd   = 1'b1;
        o_addr = a;
        @(posedge i_clk);
        #1;
        v      = i_rdata;
        o_rd   = 1'b0;
        o_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ===== sim/sbc_watchdog_unit_tb.sv
// Self-checking bench for the watchdog unit: register accesses and expected outcomes.
// Assumes the host model drives the access port; one ms is 4 clock cycles here.
`default_nettype none
module sbc_watchdog_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] A_CTL = swu_pkg::ADDR_WD_CTRL;
    localparam logic [6:0] A_ST  = swu_pkg::ADDR_WD_STATE;
    localparam logic [6:0] A_CFG = swu_pkg::ADDR_NV_CONFIG;
    logic       clk, rst_n, rx_wake_n, spi_fail_event_en, wr, rd, fail_clr;
    logic       reset_req, spi_fail, wd_fail, slp_lock, fn_state, rst_seen, spi_seen;
    logic [2:0] chip_mode;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [4:0] rsc;
    logic [1:0] uv;
    int         bad_count, n_checks, i;
    logic [3:0] per [8] = '{4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
    logic [7:0] bad [2] = '{8'h64, 8'h49};
    swu_watchdog #(.TICK_DIV(4)) u_swu_watchdog (
        .i_clk                 (clk),
        .i_rst_n               (rst_n),
        .i_chip_mode           (chip_mode),
        .i_rx_wake_n           (rx_wake_n),
        .i_spi_fail_event_en             (spi_fail_event_en),
        .i_wr                  (wr),
        .i_rd                  (rd),
        .i_addr                (addr),
        .i_wdata               (wdata),
        .i_wd_fail_clr         (fail_clr),
        .o_rdata               (rdata),
        .o_reset_req           (reset_req),
        .o_reset_source_code   (rsc),
        .o_spi_fail_event      (spi_fail),
        .o_wd_fail_event       (wd_fail),
        .o_uv_threshold_sel    (uv),
        .o_sleep_lock_ctrl     (slp_lock),
        .o_forced_normal_state (fn_state)
    );
    swu_host_model u_swu_host_model (
        .i_clk   (clk),
        .i_rdata (rdata),
        .o_wr    (wr),
        .o_rd    (rd),
        .o_addr  (addr),
        .o_wdata (wdata)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (reset_req === 1'b1) rst_seen <= 1'b1;
        if (spi_fail === 1'b1) spi_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string what);
        u_swu_host_model.rd(a, d);
        chk(what, exp, d);
    endtask
    // Waits for the reset flag (sel 0) or the failure event (sel 1)
    task automatic wait_hi(input int sel, input int n);
        for (int k = 0; k < n && (sel ? wd_fail : rst_seen) !== 1'b1; k++)
            @(posedge clk);
        #1;
        if ((sel ? wd_fail : rst_seen) !== 1'b1)
        begin
            $display("FAIL wait %0d expected 1 seen 0", sel);
            bad_count++;
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        bad_count = 0;
        n_checks  = 0;
        rst_n     = 1'b0;
        chip_mode = swu_pkg::CHIP_STANDBY;
        rx_wake_n = 1'b1;
        spi_fail_event_en   = 1'b1;
        fail_clr  = 1'b0;
        rst_seen  = 1'b0;
        spi_seen  = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rchk(A_CTL, 8'h44, "ctrl reset");
        rchk(A_CFG, swu_pkg::CFG_PRESET, "cfg reset");
        rchk(A_ST, 8'h08, "state forced");
        chk("fn out", 8'h01, {7'h0, fn_state});
        u_swu_host_model.wr(A_CFG, 8'h31);
        chk("uv out", 8'h03, {6'h0, uv});
        chk("sleep lock", 8'h01, {7'h0, slp_lock});
        rchk(A_CFG, 8'h31, "cfg rw");
        rchk(A_ST, 8'h01, "timeout first");
        for (i = 0; i < 2; i++)
        begin
            spi_seen = 1'b0;
            u_swu_host_model.wr(A_CTL, bad[i]);
            @(posedge clk);
            #1;
            chk("spi fail", 8'h01, {7'h0, spi_seen});
            rchk(A_CTL, 8'h44, "ctrl kept");
        end
        spi_fail_event_en  = 1'b0;
        spi_seen = 1'b0;
        u_swu_host_model.wr(A_CTL, bad[0]);
        @(posedge clk);
        #1;
        chk("spi fail masked", 8'h00, {7'h0, spi_seen});
        spi_fail_event_en = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            u_swu_host_model.wr(A_CTL, {swu_pkg::MODE_TIMEOUT, 1'b0, per[i]});
            rchk(A_CTL, {swu_pkg::MODE_TIMEOUT, 1'b0, per[i]}, "period code");
        end
        u_swu_host_model.wr(A_CTL, 8'h48);
        rst_seen = 1'b0;
        wait_hi(1, 48);
        chk("no reset yet", 8'h00, {7'h0, rst_seen});
        wait_hi(0, 48);
        chk("src overflow", 8'h0f, {3'h0, rsc});
        fail_clr = 1'b1;
        @(posedge clk);
        #1;
        fail_clr = 1'b0;
        rst_seen = 1'b0;
        for (i = 0; i < 3; i++)
        begin
            repeat (20) @(posedge clk);
            u_swu_host_model.wr(A_CTL, 8'h48);
        end
        chk("fail cleared", 8'h00, {7'h0, wd_fail});
        chk("no reset", 8'h00, {7'h0, rst_seen});
        chip_mode = swu_pkg::CHIP_NORMAL;
        spi_seen  = 1'b0;
        u_swu_host_model.wr(A_CTL, 8'h88);
        @(posedge clk);
        #1;
        chk("illegal reset", 8'h03, {6'h0, rst_seen, spi_seen});
        chk("src illegal", 8'h10, {3'h0, rsc});
        rchk(A_CTL, 8'h48, "ctrl locked");
        chip_mode = swu_pkg::CHIP_STANDBY;
        u_swu_host_model.wr(A_CTL, 8'h88);
        rchk(A_ST, 8'h01, "window standby");
        chip_mode = swu_pkg::CHIP_NORMAL;
        rst_seen  = 1'b0;
        u_swu_host_model.wr(A_CTL, 8'h88);
        @(posedge clk);
        #1;
        chk("early reset", 8'h01, {7'h0, rst_seen});
        chk("src early", 8'h0e, {3'h0, rsc});
        d = 8'h00;
        for (i = 0; i < 40 && d[1:0] !== swu_pkg::PH_SECOND; i++)
            u_swu_host_model.rd(A_ST, d);
        chk("second half", 8'h02, d);
        if (d !== 8'h02)
            test_done();
        rst_seen = 1'b0;
        u_swu_host_model.wr(A_CTL, 8'h88);
        rchk(A_ST, 8'h01, "window restart");
        chk("late ok", 8'h00, {7'h0, rst_seen});
        wait_hi(0, 48);
        chk("src window", 8'h0f, {3'h0, rsc});
        chip_mode = swu_pkg::CHIP_STANDBY;
        u_swu_host_model.wr(A_CTL, 8'h28);
        rchk(A_ST, 8'h00, "auto rx high");
        rx_wake_n = 1'b0;
        rchk(A_ST, 8'h01, "auto wake");
        chip_mode = swu_pkg::CHIP_SLEEP;
        rchk(A_ST, 8'h00, "auto sleep");
        u_swu_host_model.wr(A_CTL, 8'h48);
        rchk(A_ST, 8'h01, "timeout sleep");
        chip_mode = swu_pkg::CHIP_OTEMP;
        rchk(A_ST, 8'h00, "other mode");
        chip_mode = swu_pkg::CHIP_STANDBY;
        u_swu_host_model.wr(A_CFG, 8'h04);
        rchk(A_ST, 8'h05, "sw dev flag");
        u_swu_host_model.wr(A_CTL, 8'h28);
        rchk(A_ST, 8'h04, "sw dev off");
        u_swu_host_model.wr(A_CTL, 8'h48);
        chip_mode = swu_pkg::CHIP_NORMAL;
        u_swu_host_model.wr(A_CTL, 8'h88);
        chip_mode = swu_pkg::CHIP_STANDBY;
        u_swu_host_model.rd(A_CTL, d);
        chk("sw dev mode", {5'h00, swu_pkg::MODE_AUTO}, {5'h00, d[7:5]});
        test_done();
    end
endmodule
`default_nettype wire
